// file: src/cbx_top.sv
// sequencer of the compare-and-branch and middle bit-test instructions
//
// How it works
// RULE_01: opcode 11H compares accumulator with immediate; 3 bytes, 2 cycles.
// RULE_02: accumulator form branches to PC+3+offset on mismatch, else PC+3.
// RULE_03: accumulator form sets carry to accumulator < immediate (unsigned).
// RULE_04: opcode 12H, bits 7 and 0 clear: pointer form; 4 bytes, 3 cycles.
// RULE_05: indirect form compares pointed byte; mismatch branches PC+4+offset.
// RULE_06: indirect form sets carry to fetched byte < immediate.
// RULE_07: six-bit field in second byte selects pointer 0 through 63.
// RULE_08: pointer plus signed C register gives address; 4 bytes, 3 cycles.
// RULE_09: C register form carry set when byte below immediate, else cleared.
// RULE_10: opcode 12H with bit 7 set holds a 7-bit offset form.
// RULE_11: bit test branches when tested bit is 0, falls through on 1.
// RULE_12: opcode C7H tests bit field of byte at 13-bit address.
// RULE_13: offset form uses pointer zero plus signed 7-bit offset.
// RULE_14: offset form carry follows the other compare forms.
// RULE_15: relative offset is sign-extended before adding to advanced PC.
// RULE_16: opcode 02H with second byte bit 0 set is the C register form.
`timescale 1ns/10ps
`default_nettype none
module cbx_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // instruction start and core state
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] creg_in,
  input wire logic carry_in,
  // completion and results
  output logic busy_out,
  output logic done_out,
  output logic illegal_out,
  output logic [15:0] pc_out,
  output logic carry_out,
  output logic [1:0] cycles_out,
  // program memory
  output logic prog_rd_out,
  output logic [15:0] prog_addr_out,
  input wire logic [7:0] prog_data_in,
  // data memory and sfr space
  output logic data_rd_out,
  output logic [15:0] data_addr_out,
  input wire logic [7:0] data_data_in
);
  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PROG = 3'b001,
    S_PTRL = 3'b011,
    S_PTRH = 3'b010,
    S_OPND = 3'b110,
    S_EXEC = 3'b111
  } cbx_state_t;

  cbx_state_t state_ff;
  cbx_state_t nxt_state;
  logic [7:0] op_ff;
  logic [15:0] pc_ff;
  logic [7:0] acc_ff;
  logic [7:0] creg_ff;
  logic carry_ff;
  logic [7:0] ptr_lo_ff;
  logic [1:0] idx_ff;
  logic cap_ff;
  logic [1:0] cap_idx_ff;
  logic [7:0] ib_ff [1:3];
  logic done_ff;
  logic illegal_ff;
  logic [1:0] cycles_ff;

  cbx_exec_if ex ();

  // ----------------------------------------------------------------
  // decode and selection
  // ----------------------------------------------------------------
  wire logic [1:0] len;
  wire logic last_byte;
  wire cbx_pkg::cbx_form_t form;
  wire logic is_bad;
  wire logic is_cmp;
  wire logic direct_opnd;

  assign len = cbx_pkg::cbx_len(op_ff);  // [RULE_01] [RULE_04]
  assign last_byte = (idx_ff == (len - 2'h1));
  assign form = cbx_pkg::cbx_form(op_ff, ib_ff[1]);  // [RULE_10] [RULE_16]
  assign is_bad = (form == cbx_pkg::F_BAD);
  assign is_cmp = !is_bad && (form != cbx_pkg::F_BIT);
  assign direct_opnd = (op_ff == cbx_pkg::OP_CMP_IMM) ||
                       (op_ff == cbx_pkg::OP_BIT_MID);

  assign ex.form = form;
  assign ex.b1 = ib_ff[1];
  assign ex.b2 = ib_ff[2];
  assign ex.b3 = ib_ff[3];
  assign ex.ptr_lo = ptr_lo_ff;
  assign ex.ptr_hi = data_data_in;
  assign ex.creg = creg_ff;
  assign ex.pc = pc_ff;
  assign ex.opnd = (form == cbx_pkg::F_ACC) ? acc_ff : data_data_in;

  cbx_addr_gen u_agen (
    .ex (ex)
  );

  cbx_branch_unit u_bru (
    .ex (ex)
  );

  // ----------------------------------------------------------------
  // memory requests
  // ----------------------------------------------------------------
  assign prog_rd_out = (state_ff == S_PROG);
  assign prog_addr_out = pc_ff + {14'h0000, idx_ff};
  assign data_rd_out = !is_bad &&
                       ((state_ff == S_PTRL) || (state_ff == S_PTRH) ||
                        ((state_ff == S_OPND) &&
                         (form != cbx_pkg::F_ACC)));
  assign data_addr_out = (state_ff == S_PTRL) ? ex.ptr_addr :
                         (state_ff == S_PTRH) ? ex.ptr_addr + 16'h0001 :
                         ex.addr;  // [RULE_08] [RULE_13]

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (start_in) begin
          nxt_state = S_PROG;
        end
      end
      S_PROG: begin
        if (last_byte) begin
          nxt_state = direct_opnd ? S_OPND : S_PTRL;
        end
      end
      S_PTRL: nxt_state = S_PTRH;
      S_PTRH: nxt_state = S_OPND;
      S_OPND: nxt_state = S_EXEC;
      S_EXEC: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_ff <= S_IDLE;
      idx_ff <= cbx_pkg::IDX_FIRST;
      cap_ff <= 1'b0;
      cap_idx_ff <= cbx_pkg::IDX_FIRST;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= (state_ff == S_PROG) ? idx_ff + 2'h1 : cbx_pkg::IDX_FIRST;
      cap_ff <= prog_rd_out;
      cap_idx_ff <= idx_ff;
    end
  end

  // instruction bytes land one clock after their fetch
  for (genvar g = 1; g <= 3; g++) begin : g_ib
    always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
        ib_ff[g] <= cbx_pkg::BYTE_RST;
      end else if (cap_ff && cap_idx_ff == 2'(g)) begin
        ib_ff[g] <= prog_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      op_ff <= cbx_pkg::BYTE_RST;
      acc_ff <= cbx_pkg::BYTE_RST;
      creg_ff <= cbx_pkg::BYTE_RST;
      ptr_lo_ff <= cbx_pkg::BYTE_RST;
    end else begin
      if (state_ff == S_IDLE && start_in) begin
        op_ff <= opcode_in;
        acc_ff <= acc_in;
        creg_ff <= creg_in;
      end
      if (state_ff == S_PTRH) begin
        ptr_lo_ff <= data_data_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pc_ff <= cbx_pkg::PC_RST;
      carry_ff <= 1'b0;
    end else if (state_ff == S_IDLE && start_in) begin
      pc_ff <= pc_in;
      carry_ff <= carry_in;
    end else if (state_ff == S_EXEC && !is_bad) begin
      pc_ff <= ex.target;  // [RULE_02] [RULE_05] [RULE_08] [RULE_12]
      carry_ff <= is_cmp ? ex.less : carry_ff;  // [RULE_09] [RULE_14]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      cycles_ff <= 2'h0;
    end else begin
      done_ff <= (state_ff == S_EXEC);
      if (state_ff == S_EXEC) begin
        illegal_ff <= is_bad;
        cycles_ff <= (form == cbx_pkg::F_ACC) ? cbx_pkg::CYC_2 :
                     cbx_pkg::CYC_3;  // [RULE_01] [RULE_04]
      end
    end
  end

  assign busy_out = (state_ff != S_IDLE);
  assign done_out = done_ff;
  assign illegal_out = illegal_ff;
  assign pc_out = pc_ff;
  assign carry_out = carry_ff;
  assign cycles_out = cycles_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  wire logic exec_acc;
  wire logic exec_ind;
  assign exec_acc = (state_ff == S_EXEC) && (form == cbx_pkg::F_ACC);
  assign exec_ind = (state_ff == S_EXEC) && is_cmp &&
                    (form != cbx_pkg::F_ACC);

  property p_acc_fetch;
    (state_ff == S_IDLE && start_in && opcode_in == 8'h11) |=>
      prog_rd_out [*2] ##1 !prog_rd_out ##2 done_out;
  endproperty
  a_acc_fetch: assert property (p_acc_fetch) // [RULE_01]
    else $error("acc fetch");

  property p_acc_pc;
    exec_acc |=> pc_out == $past(pc_ff) + 16'h0003 +
      (($past(acc_ff) != $past(ib_ff[1])) ?
       {{8{$past(ib_ff[2][7])}}, $past(ib_ff[2])} : 16'h0000);
  endproperty
  a_acc_pc: assert property (p_acc_pc) else $error("acc pc"); // [RULE_02]

  property p_acc_cy;
    exec_acc |=> carry_out == ($past(acc_ff) < $past(ib_ff[1]));
  endproperty
  a_acc_cy: assert property (p_acc_cy) else $error("acc carry"); // [RULE_03]

  property p_ind_fetch;
    (state_ff == S_IDLE && start_in && opcode_in == 8'h12) |=>
      prog_rd_out [*3] ##1 !prog_rd_out ##[3:4] done_out;
  endproperty
  a_ind_fetch: assert property (p_ind_fetch) // [RULE_04]
    else $error("ind fetch");

  property p_ind_pc;
    exec_ind |=> pc_out == $past(pc_ff) + 16'h0004 +
      (($past(data_data_in) != $past(ib_ff[2])) ?
       {{8{$past(ib_ff[3][7])}}, $past(ib_ff[3])} : 16'h0000);
  endproperty
  a_ind_pc: assert property (p_ind_pc) else $error("ind pc"); // [RULE_05]

  property p_ind_cy;
    exec_ind |=> carry_out == ($past(data_data_in) < $past(ib_ff[2]));
  endproperty
  a_ind_cy: assert property (p_ind_cy) else $error("ind carry"); // [RULE_06]

  property p_ptr_addr;
    (state_ff == S_PTRL && form == cbx_pkg::F_IND) |->
      data_rd_out && data_addr_out == {9'h000, ib_ff[1][6:1], 1'b0};
  endproperty
  a_ptr_addr: assert property (p_ptr_addr) // [RULE_07]
    else $error("ptr addr");

  property p_idc_addr;
    (state_ff == S_OPND && form == cbx_pkg::F_IDC) |->
      data_addr_out == {data_data_in, ptr_lo_ff} +
                       {{8{creg_ff[7]}}, creg_ff};
  endproperty
  a_idc_addr: assert property (p_idc_addr) // [RULE_08]
    else $error("creg addr");

  property p_off_addr;
    (state_ff == S_PTRL && form == cbx_pkg::F_OFF) |->
      data_addr_out == 16'h0000 ##2
      data_addr_out == {data_data_in, ptr_lo_ff} +
                       {{9{ib_ff[1][6]}}, ib_ff[1][6:0]};
  endproperty
  a_off_addr: assert property (p_off_addr) // [RULE_13]
    else $error("off addr");

  property p_bit_pc;
    (state_ff == S_EXEC && form == cbx_pkg::F_BIT) |=>
      carry_out == $past(carry_ff) &&
      pc_out == $past(pc_ff) + 16'h0004 +
      (!$past(data_data_in[ib_ff[2][7:5]]) ?
       {{8{$past(ib_ff[3][7])}}, $past(ib_ff[3])} : 16'h0000);
  endproperty
  a_bit_pc: assert property (p_bit_pc) else $error("bit pc"); // [RULE_11]

  c_acc_taken: cover property (exec_acc && ex.take);
  c_ind_equal: cover property (exec_ind && !ex.take);
  c_bit_taken: cover property (state_ff == S_EXEC &&
                               form == cbx_pkg::F_BIT && ex.take);
  c_illegal: cover property (done_out && illegal_out);
endmodule
`default_nettype wire

// file: src/cbx_pkg.sv
// constants, types and decode functions of the compare-branch unit
package cbx_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CMP_IMM = 8'h11;
  localparam logic [7:0] OP_CMP_IND = 8'h12;
  localparam logic [7:0] OP_CMP_IDC = 8'h02;
  localparam logic [7:0] OP_BIT_MID = 8'hC7;

  // ----------------------------------------------------------------
  // lengths and documented instruction cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [1:0] LEN_4 = 2'h0;
  localparam logic [15:0] PC_STEP_3 = 16'h0003;
  localparam logic [15:0] PC_STEP_4 = 16'h0004;
  localparam logic [1:0] CYC_2 = 2'h2;
  localparam logic [1:0] CYC_3 = 2'h3;
  localparam logic [1:0] IDX_FIRST = 2'h1;

  // ----------------------------------------------------------------
  // field positions of the second and third bytes
  // ----------------------------------------------------------------
  localparam int OFF_FORM_BIT = 7;
  localparam int IDC_FORM_BIT = 0;
  localparam int PTR_LSB = 1;
  localparam int PTR_MSB = 6;
  localparam int OFF_MSB = 6;
  localparam int BIT_SEL_LSB = 5;
  localparam int MID_HI_MSB = 4;
  localparam int NUM_PTR = 64;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    F_ACC = 3'h0,
    F_IND = 3'h1,
    F_IDC = 3'h2,
    F_OFF = 3'h3,
    F_BIT = 3'h4,
    F_BAD = 3'h5
  } cbx_form_t;

  // instruction length in bytes, low two bits (4 wraps to 0)
  function automatic logic [1:0] cbx_len(input logic [7:0] op);
    cbx_len = (op == OP_CMP_IMM) ? LEN_3 : LEN_4;
  endfunction

  // operand form from opcode and second byte
  function automatic cbx_form_t cbx_form(input logic [7:0] op,
                                         input logic [7:0] b1);
    cbx_form = F_BAD;
    if (op == OP_CMP_IMM) begin
      cbx_form = F_ACC;
    end else if (op == OP_BIT_MID) begin
      cbx_form = F_BIT;
    end else if (op == OP_CMP_IDC && b1[IDC_FORM_BIT]) begin
      cbx_form = F_IDC;
    end else if (op == OP_CMP_IND && b1[OFF_FORM_BIT]) begin
      cbx_form = F_OFF;
    end else if (op == OP_CMP_IND && !b1[IDC_FORM_BIT]) begin
      cbx_form = F_IND;
    end
  endfunction

endpackage

// file: src/cbx_exec_if.sv
// operands and results passed between sequencer, address and branch units
`timescale 1ns/10ps
`default_nettype none
interface cbx_exec_if;
  cbx_pkg::cbx_form_t form;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [7:0] ptr_lo;
  logic [7:0] ptr_hi;
  logic [7:0] creg;
  logic [7:0] opnd;
  logic [15:0] pc;
  logic [15:0] ptr_addr;
  logic [15:0] addr;
  logic [15:0] target;
  logic take;
  logic less;

  modport ctl (output form, b1, b2, b3, ptr_lo, ptr_hi, creg, opnd, pc,
               input ptr_addr, addr, target, take, less);
  modport agen (input form, b1, b2, ptr_lo, ptr_hi, creg,
                output ptr_addr, addr);
  modport bru (input form, b1, b2, b3, opnd, pc,
               output target, take, less);
endinterface
`default_nettype wire

// file: src/cbx_addr_gen.sv
// data address generation for pointer and middle-range operands
`timescale 1ns/10ps
`default_nettype none
module cbx_addr_gen (
  cbx_exec_if.agen ex
);
  // ----------------------------------------------------------------
  // pointer word and displacement
  // ----------------------------------------------------------------
  wire logic [5:0] ptr_num;
  wire logic [15:0] disp;
  wire logic [15:0] base;

  // pointer low byte at 2n, high byte at 2n+1
  assign ptr_num = (ex.form == cbx_pkg::F_OFF) ? 6'h00 :
                   ex.b1[cbx_pkg::PTR_MSB:cbx_pkg::PTR_LSB];  // [RULE_07]
  assign ex.ptr_addr = {9'h000, ptr_num, 1'b0};  // [RULE_13]

  assign disp = (ex.form == cbx_pkg::F_IDC) ?
                  {{8{ex.creg[7]}}, ex.creg} :  // [RULE_08]
                (ex.form == cbx_pkg::F_OFF) ?
                  {{9{ex.b1[cbx_pkg::OFF_MSB]}},
                   ex.b1[cbx_pkg::OFF_MSB:0]} :  // [RULE_13]
                16'h0000;

  assign base = {ex.ptr_hi, ex.ptr_lo};

  // 13-bit middle-range address for the bit test
  assign ex.addr = (ex.form == cbx_pkg::F_BIT) ?
                   {3'h0, ex.b2[cbx_pkg::MID_HI_MSB:0], ex.b1} :  // [RULE_12]
                   base + disp;  // [RULE_05]
endmodule
`default_nettype wire

// file: src/cbx_branch_unit.sv
// compare, carry and branch target computation
`timescale 1ns/10ps
`default_nettype none
module cbx_branch_unit (
  cbx_exec_if.bru ex
);
  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  wire logic is_acc;
  wire logic [7:0] imm;
  wire logic [7:0] rel;
  wire logic [2:0] bit_sel;
  wire logic [15:0] step;
  wire logic [15:0] next_pc;

  assign is_acc = (ex.form == cbx_pkg::F_ACC);
  assign imm = is_acc ? ex.b1 : ex.b2;
  assign rel = is_acc ? ex.b2 : ex.b3;
  assign bit_sel = ex.b2[7:cbx_pkg::BIT_SEL_LSB];
  assign step = is_acc ? cbx_pkg::PC_STEP_3 : cbx_pkg::PC_STEP_4;  // [RULE_01]

  // ----------------------------------------------------------------
  // decision and target
  // ----------------------------------------------------------------
  assign ex.take = (ex.form == cbx_pkg::F_BIT) ?
                   !ex.opnd[bit_sel] :  // [RULE_11]
                   (ex.opnd != imm);  // [RULE_02] [RULE_05]
  assign ex.less = (ex.opnd < imm);  // [RULE_03] [RULE_06]
  assign next_pc = ex.pc + step;
  assign ex.target = ex.take ?
                     next_pc + {{8{rel[7]}}, rel} :  // [RULE_15]
                     next_pc;
endmodule
`default_nettype wire

// file: verification/cbx_mem_model.sv
// program memory and data/sfr space model on the far side of the unit
`timescale 1ns/10ps
`default_nettype none
module cbx_mem_model (
  // clock
  input wire logic clk_in,
  // program memory side
  input wire logic prog_rd_in,
  input wire logic [15:0] prog_addr_in,
  output logic [7:0] prog_data_out,
  // data memory side
  input wire logic data_rd_in,
  input wire logic [15:0] data_addr_in,
  output logic [7:0] data_data_out
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] pmem [0:65535];
  logic [7:0] dmem [0:65535];

  initial begin
    prog_data_out = 8'h00;
    data_data_out = 8'h00;
  end

  // ----------------------------------------------------------------
  // answer one clock after the strobe, inverted last value when idle
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (prog_rd_in) begin
      prog_data_out <= pmem[prog_addr_in];
    end else begin
      prog_data_out <= ~prog_data_out;
    end
    if (data_rd_in) begin
      data_data_out <= dmem[data_addr_in];
    end else begin
      data_data_out <= ~data_data_out;
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench of the compare-branch unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk_in, resetn_in, start_in, carry_in;
  logic [7:0] opcode_in, acc_in, creg_in;
  logic [15:0] pc_in;
  logic busy_out, done_out, illegal_out, carry_out;
  logic [15:0] pc_out, prog_addr_out, data_addr_out;
  logic [1:0] cycles_out;
  logic prog_rd_out, data_rd_out;
  logic [7:0] prog_data_in, data_data_in;
  int seed = 32'h93BB3685;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  cbx_top dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .start_in(start_in), .opcode_in(opcode_in), .pc_in(pc_in),
    .acc_in(acc_in), .creg_in(creg_in), .carry_in(carry_in),
    .busy_out(busy_out), .done_out(done_out), .illegal_out(illegal_out),
    .pc_out(pc_out), .carry_out(carry_out), .cycles_out(cycles_out),
    .prog_rd_out(prog_rd_out), .prog_addr_out(prog_addr_out),
    .prog_data_in(prog_data_in), .data_rd_out(data_rd_out),
    .data_addr_out(data_addr_out), .data_data_in(data_data_in));

  cbx_mem_model mem (.clk_in(ref_clk_in), .prog_rd_in(prog_rd_out),
    .prog_addr_in(prog_addr_out), .prog_data_out(prog_data_in),
    .data_rd_in(data_rd_out), .data_addr_in(data_addr_out),
    .data_data_out(data_data_in));

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one instruction: build, run, compare with the reference
  // ----------------------------------------------------------------
  task automatic run(input int f, input int i);
    logic [7:0] op, b1, b2, b3, cr, acc, imm, rel, opnd;
    logic [15:0] pc, ptr, addr, exp_pc;
    logic [5:0] n;
    logic [6:0] ofs;
    logic [2:0] bsel;
    logic cin, take, exp_cy, bad;
    int len, lat, k;
    pc = 16'($random(seed));
    acc = 8'($random(seed));
    cr = 8'($random(seed));
    cin = 1'($random(seed));
    imm = 8'($random(seed));
    rel = 8'($random(seed));
    opnd = 8'($random(seed));
    n = (i % 4 == 0) ? 6'h3F : (i % 4 == 1) ? 6'h00 : 6'($random(seed));
    ofs = (i % 4 == 0) ? 7'h40 : (i % 4 == 1) ? 7'h3F : 7'($random(seed));
    if (i % 4 == 0) cr = 8'h80;
    if (i % 4 == 1) cr = 8'h7F;
    ptr = (16'($random(seed)) & 16'h7FFF) | 16'h0200;
    bsel = 3'($random(seed));
    b1 = 8'($random(seed));
    bad = 1'b0;
    len = 4;
    lat = 7;
    op = cbx_pkg::OP_CMP_IND;
    if (f == 3) n = 6'h00;
    mem.dmem[{9'h000, n, 1'b0}] = ptr[7:0];
    mem.dmem[{9'h000, n, 1'b1}] = ptr[15:8];
    case (f)
      0: begin
        op = cbx_pkg::OP_CMP_IMM;
        len = 3;
        lat = 4;
        opnd = acc;
        if (i % 2 == 0) imm = acc;
        b1 = imm;
        b2 = rel;
      end
      4: begin
        op = cbx_pkg::OP_BIT_MID;
        lat = 5;
        b2 = {bsel, 5'($random(seed))};
        addr = {3'h0, b2[4:0], b1};
        mem.dmem[addr] = opnd;
      end
      5: begin
        op = cbx_pkg::OP_CMP_IDC;
        b1 = {b1[7:1], 1'b0};
        bad = 1'b1;
      end
      6: begin
        b1 = {1'b0, b1[6:1], 1'b1};
        bad = 1'b1;
      end
      default: begin
        addr = ptr;
        if (f == 1) b1 = {1'b0, n, 1'b0};
        if (f == 2) begin
          op = cbx_pkg::OP_CMP_IDC;
          b1 = {1'b0, n, 1'b1};
          addr = ptr + {{8{cr[7]}}, cr};
        end
        if (f == 3) begin
          b1 = {1'b1, ofs};
          addr = ptr + {{9{ofs[6]}}, ofs};
        end
        mem.dmem[addr] = opnd;
        if (i % 2 == 0) imm = opnd;
        b2 = imm;
      end
    endcase
    if (f != 0) b3 = rel;
    if (f == 0) b3 = 8'($random(seed));
    mem.pmem[pc + 16'h0001] = b1;
    mem.pmem[pc + 16'h0002] = b2;
    mem.pmem[pc + 16'h0003] = b3;
    take = (f == 4) ? !opnd[bsel] : (opnd != imm);
    exp_cy = (f == 4) ? cin : (opnd < imm);
    exp_pc = pc + 16'(len) + (take ? {{8{rel[7]}}, rel} : 16'h0000);
    opcode_in = op;
    pc_in = pc;
    acc_in = acc;
    creg_in = cr;
    carry_in = cin;
    start_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    start_in = 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 20) begin
      @(posedge ref_clk_in);
      #1;
      k++;
      if (k == 1) `CHK(busy_out, 1'b1)
      if (k == 1) `CHK(prog_rd_out, 1'b1)
      if (k == 1) `CHK(prog_addr_out, pc + 16'h0002)
      if (k == 3) `CHK(data_rd_out, !(f == 0 || bad))
      if (k == 3 && f != 0 && !bad) begin
        `CHK(data_addr_out, (f == 4) ? addr : {9'h000, n, 1'b0})
      end
      start_in = (k == 2);
      opcode_in = ~op;
    end
    `CHK(done_out, 1'b1)
    `CHK(busy_out, 1'b0)
    if (!bad) `CHK(k, lat)
    `CHK(illegal_out, bad)
    if (!bad) begin
      `CHK(pc_out, exp_pc)
      `CHK(carry_out, exp_cy)
      `CHK(cycles_out, (f == 0) ? cbx_pkg::CYC_2 : cbx_pkg::CYC_3)
    end else begin
      `CHK(pc_out, pc)
      `CHK(carry_out, cin)
    end
    @(posedge ref_clk_in);
    #1;
    `CHK(done_out, 1'b0)
    if (!bad) `CHK(pc_out, exp_pc)
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn_in = 1'b0;
    start_in = 1'b0;
    opcode_in = 8'h00;
    pc_in = 16'h0000;
    acc_in = 8'h00;
    creg_in = 8'h00;
    carry_in = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    #1;
    resetn_in = 1'b1;
    `CHK(busy_out, 1'b0)
    `CHK(pc_out, cbx_pkg::PC_RST)
    `CHK(carry_out, 1'b0)
    for (int i = 0; i < 140; i++) begin
      run(i % 7, i / 7);
    end
    conclude();
  end
endmodule
`default_nettype wire
